//--- core/gpio_cfg_pkg.sv
package gpio_cfg_pkg;

   // bus geometry
   localparam int ADDR_W   = 8;
   localparam int DATA_W   = 8;
   localparam int NUM_PINS = 8;

   // pin configuration register offsets
   localparam logic [7:0] OFF_PORT3_PIN2  = 8'h35;
   localparam logic [7:0] OFF_PORT3_PIN3  = 8'h36;
   localparam logic [7:0] OFF_PORT3_PIN4  = 8'h37;
   localparam logic [7:0] OFF_PORT3_PIN5  = 8'h38;
   localparam logic [7:0] OFF_PORT3_PIN6  = 8'h39;
   localparam logic [7:0] OFF_PORT3_PIN7  = 8'h3a;
   localparam logic [7:0] OFF_PORT4_PIN0  = 8'h3b;
   localparam logic [7:0] OFF_PORT4_PIN1  = 8'h3c;

   // data, level and interrupt registers
   localparam logic [7:0] OFF_DATA_OUT    = 8'h50;
   localparam logic [7:0] OFF_PIN_LEVEL   = 8'h51;
   localparam logic [7:0] OFF_IRQ_STATUS  = 8'h52;
   localparam logic [7:0] OFF_IRQ_MASK    = 8'h53;

   // field positions inside a configuration register
   localparam int BIT_DIR    = 0;
   localparam int BIT_POL    = 1;
   localparam int BIT_ALT    = 2;
   localparam int BIT_SEL_HI = 3;
   localparam int BIT_ODRAIN = 7;

   // register index of special pins
   localparam logic [2:0] IDX_FAN     = 3'h1;
   localparam logic [2:0] IDX_TWO_SEL = 3'h7;

   // reset values and implemented-bit masks
   localparam logic [7:0] CFG_RESET      = 8'h01;
   localparam logic [7:0] FAN_MAIN_RESET = 8'h00;
   localparam logic [7:0] MASK_ONE_SEL   = 8'h87;
   localparam logic [7:0] MASK_TWO_SEL   = 8'h8f;
   localparam logic [7:0] DATA_RESET     = 8'h00;

   // selector codes of the two-bit pin
   typedef enum logic [1:0] {
      SEL_PLAIN    = 2'b00,
      SEL_DENSITY  = 2'b01,
      SEL_EDGE_IRQ = 2'b10,
      SEL_RSVD     = 2'b11
   } pin_mode_t;

endpackage

//--- core/gpio_pin_config.sv
`timescale 1ns/1ps
// Summary of operation
// RULE_01 - bit 0: one means input, zero output
// RULE_02 - bit 1 inverts pin versus internal value
// RULE_03 - bit 7: open drain, else push pull
// RULE_04 - bit 2 routes pin to alternate function
// RULE_05 - offset 35h pin carries smbus data
// RULE_06 - offset 36h fan output, main reset clears
// RULE_07 - offset 37h pin carries interrupt line twelve
// RULE_08 - offset 38h pin carries interrupt line fourteen
// RULE_09 - offset 39h pin carries keyboard reset low
// RULE_10 - offset 3ah pin carries address20 gate low
// RULE_11 - offset 3bh pin carries density select zero
// RULE_12 - offset 3ch two bit selector choice
// RULE_13 - selector 10 gives either edge interrupt
// RULE_14 - reserved bits read zero, code 11 plain
// RULE_15 - all configuration registers reset to 01h
module gpio_pin_config
   import gpio_cfg_pkg::*;
#(
   parameter int NPINS = NUM_PINS
) (
   input  wire logic              i_ref_clk,
   input  wire logic              i_rst,
   input  wire logic              i_main_rst,
   input  wire logic [ADDR_W-1:0] i_addr,
   input  wire logic [DATA_W-1:0] i_wr_data,
   input  wire logic              i_wr,
   input  wire logic              i_rd,
   output logic      [DATA_W-1:0] o_rd_data,
   input  wire logic [NPINS-1:0]  i_pin_level,
   output logic      [NPINS-1:0]  o_pin_out,
   output logic      [NPINS-1:0]  o_pin_oe,
   output logic      [NPINS-1:0]  o_pin_value,
   input  wire logic              i_smbus_data_line,
   input  wire logic              i_fan_ctrl,
   input  wire logic              i_irq12,
   input  wire logic              i_irq14,
   input  wire logic              i_keyboard_reset_out_n,
   input  wire logic              i_gate_address20_out_n,
   input  wire logic              i_drive_density_select0,
   input  wire logic              i_drive_density_select1,
   output logic                   o_irq
);

   // the register map is fixed at eight pins
   if (NPINS != NUM_PINS) begin : g_bad_npins
      $error("gpio_pin_config supports exactly eight pins");
   end

   // implemented bits differ for the two-bit selector pin
   function automatic logic [7:0] write_mask(input logic [2:0] idx);
      return (idx == IDX_TWO_SEL) ? MASK_TWO_SEL : MASK_ONE_SEL; // RULE_14
   endfunction

   logic [7:0]       cfg_r [NPINS];
   logic [7:0]       cfg_nxt [NPINS];
   logic [NPINS-1:0] data_out_r;
   logic [NPINS-1:0] data_out_nxt;
   logic [NPINS-1:0] pin_s1_r;
   logic [NPINS-1:0] pin_s2_r;
   logic             edge_prev_r;
   logic             main_s1_r;
   logic             main_s2_r;
   logic             irq_status_r;
   logic             irq_status_nxt;
   logic             irq_mask_r;
   logic             irq_mask_nxt;

   // bus decode
   wire              cfg_hit   = (i_addr >= OFF_PORT3_PIN2) && (i_addr <= OFF_PORT4_PIN1);
   wire [2:0]        cfg_idx   = 3'(i_addr - OFF_PORT3_PIN2);
   wire              wr_cfg    = i_wr && cfg_hit;
   wire              wr_data   = i_wr && (i_addr == OFF_DATA_OUT);
   wire              wr_status = i_wr && (i_addr == OFF_IRQ_STATUS);
   wire              wr_mask   = i_wr && (i_addr == OFF_IRQ_MASK);

   // per-pin configuration fields
   logic [NPINS-1:0] dir_in;
   logic [NPINS-1:0] pol;
   logic [NPINS-1:0] odrain;
   logic [NPINS-1:0] alt_on;
   wire  [1:0]       sel_two   = cfg_r[IDX_TWO_SEL][BIT_SEL_HI:BIT_ALT];
   wire              edge_mode = (sel_two == SEL_EDGE_IRQ);

   // alternate sources, in register order from 35h upward
   wire [NPINS-1:0]  alt_val = {i_drive_density_select1, i_drive_density_select0, // RULE_11 RULE_12
                                i_gate_address20_out_n, i_keyboard_reset_out_n, // RULE_09 RULE_10
                                i_irq14, i_irq12, i_fan_ctrl, i_smbus_data_line}; // RULE_05 RULE_06 RULE_07 RULE_08

   logic [NPINS-1:0] src_val;
   logic [NPINS-1:0] drive_lvl;
   logic [NPINS-1:0] as_input;
   logic [NPINS-1:0] oe_nxt;
   logic [NPINS-1:0] out_nxt;

   for (genvar g = 0; g < NPINS; g++) begin : g_pin
      assign dir_in[g] = cfg_r[g][BIT_DIR];
      assign pol[g]    = cfg_r[g][BIT_POL];
      assign odrain[g] = cfg_r[g][BIT_ODRAIN];
      // code 11 falls back to plain i/o, like 00
      assign alt_on[g] = (3'(g) == IDX_TWO_SEL) ? (sel_two == SEL_DENSITY) // RULE_12 RULE_14
                                                : cfg_r[g][BIT_ALT]; // RULE_04
      // register write, main-power reset clears only the fan pin
      assign cfg_nxt[g] = (3'(g) == IDX_FAN && main_s2_r) ? FAN_MAIN_RESET // RULE_06
                        : (wr_cfg && cfg_idx == 3'(g)) ? (i_wr_data & write_mask(3'(g))) // RULE_14
                        : cfg_r[g];
   end

   // pin drive: polarity, direction, driver type
   assign src_val   = (alt_on & alt_val) | (~alt_on & data_out_r); // RULE_04
   assign drive_lvl = src_val ^ pol; // RULE_02
   // edge interrupt mode forces the pin to input
   assign as_input  = dir_in | {edge_mode, {(NPINS-1){1'b0}}}; // RULE_01 RULE_13
   assign oe_nxt    = ~as_input & (~odrain | ~drive_lvl); // RULE_01 RULE_03
   assign out_nxt   = drive_lvl & ~odrain; // RULE_03

   // either-edge detection on the synchronised pin
   wire edge_evt = edge_mode && (pin_s2_r[IDX_TWO_SEL] != edge_prev_r); // RULE_13

   // sticky status: a new edge wins over a write-one clear
   assign irq_status_nxt = edge_evt | (irq_status_r & ~(wr_status & i_wr_data[0])); // RULE_13
   assign irq_mask_nxt   = wr_mask ? i_wr_data[0] : irq_mask_r;
   assign data_out_nxt   = wr_data ? i_wr_data : data_out_r;

   // synced level through the polarity bit, shared by level register and pad value
   wire [NPINS-1:0] in_val      = pin_s2_r ^ pol; // RULE_02
   wire [7:0]       cfg_at_addr = cfg_r[cfg_idx];

   // read mux; unmapped offsets answer zero
   wire [7:0] rd_mux = cfg_hit ? (cfg_at_addr & write_mask(cfg_idx)) // RULE_14
                     : (i_addr == OFF_DATA_OUT)   ? data_out_r
                     : (i_addr == OFF_PIN_LEVEL)  ? in_val // RULE_02
                     : (i_addr == OFF_IRQ_STATUS) ? {7'h00, irq_status_r}
                     : (i_addr == OFF_IRQ_MASK)   ? {7'h00, irq_mask_r}
                     : 8'h00;

   // configuration registers, standby-power reset; reset test outermost for plain async flops
   always_ff @(posedge i_ref_clk or posedge i_rst) begin
      if (i_rst) begin
         for (int i = 0; i < NPINS; i++) begin
            cfg_r[i] <= CFG_RESET; // RULE_15
         end
      end else begin
         for (int i = 0; i < NPINS; i++) begin
            cfg_r[i] <= cfg_nxt[i];
         end
      end
   end

   // pin and main-reset synchronisers
   always_ff @(posedge i_ref_clk or posedge i_rst) begin
      if (i_rst) begin
         pin_s1_r    <= '0;
         pin_s2_r    <= '0;
         edge_prev_r <= 1'b0;
         main_s1_r   <= 1'b0;
         main_s2_r   <= 1'b0;
      end else begin
         pin_s1_r    <= i_pin_level;
         pin_s2_r    <= pin_s1_r;
         edge_prev_r <= pin_s2_r[IDX_TWO_SEL];
         main_s1_r   <= i_main_rst;
         main_s2_r   <= main_s1_r;
      end
   end

   // data, interrupt state and registered outputs
   always_ff @(posedge i_ref_clk or posedge i_rst) begin
      if (i_rst) begin
         data_out_r   <= DATA_RESET;
         irq_status_r <= 1'b0;
         irq_mask_r   <= 1'b0;
         o_irq        <= 1'b0;
         o_rd_data    <= 8'h00;
         o_pin_out    <= '0;
         o_pin_oe     <= '0;
         o_pin_value  <= '0;
      end else begin
         data_out_r   <= data_out_nxt;
         irq_status_r <= irq_status_nxt;
         irq_mask_r   <= irq_mask_nxt;
         o_irq        <= irq_status_nxt & irq_mask_nxt;
         o_rd_data    <= i_rd ? rd_mux : 8'h00;
         o_pin_out    <= out_nxt;
         o_pin_oe     <= oe_nxt;
         o_pin_value  <= in_val; // RULE_02
      end
   end

   // checks on the design's own registers and outputs
   default clocking cb @(posedge i_ref_clk);
   endclocking
   default disable iff (i_rst);

   property p_dir_input;
      cfg_r[0][BIT_DIR] |=> !o_pin_oe[0];
   endproperty
   a_dir_input: assert property (p_dir_input) else $error("input pin is driven"); // RULE_01

   property p_push_pull_gpio;
      (!cfg_r[2][BIT_DIR] && !cfg_r[2][BIT_ODRAIN] && !cfg_r[2][BIT_ALT])
         |=> o_pin_oe[2] && (o_pin_out[2] == ($past(data_out_r[2]) ^ $past(cfg_r[2][BIT_POL])));
   endproperty
   a_push_pull_gpio: assert property (p_push_pull_gpio) else $error("gpio level or polarity wrong"); // RULE_02

   property p_open_drain;
      (!cfg_r[3][BIT_DIR] && cfg_r[3][BIT_ODRAIN] && !cfg_r[3][BIT_ALT])
         |=> !o_pin_out[3] && (o_pin_oe[3] == !($past(data_out_r[3]) ^ $past(cfg_r[3][BIT_POL])));
   endproperty
   a_open_drain: assert property (p_open_drain) else $error("open drain drove high"); // RULE_03

   property p_alt_irq14;
      (cfg_r[3'h3][7:0] == 8'h04) |=> o_pin_oe[3] && (o_pin_out[3] == $past(i_irq14));
   endproperty
   a_alt_irq14: assert property (p_alt_irq14) else $error("interrupt fourteen not routed"); // RULE_08

   property p_smbus_od;
      (cfg_r[0] == 8'h84) |=> !o_pin_out[0] && (o_pin_oe[0] == !$past(i_smbus_data_line));
   endproperty
   a_smbus_od: assert property (p_smbus_od) else $error("smbus data not routed"); // RULE_05

   property p_fan_main_reset;
      main_s2_r |=> (cfg_r[IDX_FAN] == FAN_MAIN_RESET);
   endproperty
   a_fan_main_reset: assert property (p_fan_main_reset) else $error("fan config not cleared"); // RULE_06

   property p_reserved_read;
      (i_rd && cfg_hit) |=> ((o_rd_data & ~write_mask($past(cfg_idx))) == 8'h00);
   endproperty
   a_reserved_read: assert property (p_reserved_read) else $error("reserved bits read nonzero"); // RULE_14

   property p_rsvd_code_plain;
      (cfg_r[IDX_TWO_SEL][7:0] == 8'h0c) |=> o_pin_oe[7] && (o_pin_out[7] == $past(data_out_r[7]));
   endproperty
   a_rsvd_code_plain: assert property (p_rsvd_code_plain) else $error("code 11 not plain i/o"); // RULE_14

   property p_density1;
      (cfg_r[IDX_TWO_SEL][7:0] == 8'h04) |=> (o_pin_out[7] == $past(i_drive_density_select1));
   endproperty
   a_density1: assert property (p_density1) else $error("density select one not routed"); // RULE_12

   property p_edge_sets_status;
      (edge_mode && $changed(pin_s2_r[7])) |=> irq_status_r ##0 (o_irq == irq_mask_r);
   endproperty
   a_edge_sets_status: assert property (p_edge_sets_status) else $error("edge did not set status"); // RULE_13

   property p_edge_pin_input;
      edge_mode |=> !o_pin_oe[7];
   endproperty
   a_edge_pin_input: assert property (p_edge_pin_input) else $error("edge input pin driven"); // RULE_13

   // fan, interrupt twelve, keyboard reset, address20 gate and density select zero each reach their own pad as push-pull outputs
   property p_alt_fan;
      (cfg_r[IDX_FAN] == 8'h04) |=> o_pin_oe[1] && (o_pin_out[1] == $past(i_fan_ctrl));
   endproperty
   a_alt_fan: assert property (p_alt_fan) else $error("fan output not routed"); // RULE_06

   property p_alt_irq12;
      (cfg_r[2] == 8'h04) |=> o_pin_oe[2] && (o_pin_out[2] == $past(i_irq12));
   endproperty
   a_alt_irq12: assert property (p_alt_irq12) else $error("interrupt twelve not routed"); // RULE_07

   property p_alt_kbd_reset;
      (cfg_r[4] == 8'h04) |=> o_pin_oe[4] && (o_pin_out[4] == $past(i_keyboard_reset_out_n));
   endproperty
   a_alt_kbd_reset: assert property (p_alt_kbd_reset) else $error("keyboard reset not routed"); // RULE_09

   property p_alt_gate_a20;
      (cfg_r[5] == 8'h04) |=> o_pin_oe[5] && (o_pin_out[5] == $past(i_gate_address20_out_n));
   endproperty
   a_alt_gate_a20: assert property (p_alt_gate_a20) else $error("address20 gate not routed"); // RULE_10

   property p_alt_density0;
      (cfg_r[6] == 8'h04) |=> o_pin_oe[6] && (o_pin_out[6] == $past(i_drive_density_select0));
   endproperty
   a_alt_density0: assert property (p_alt_density0) else $error("density select zero not routed"); // RULE_11

   // main-power reset must leave the smbus pin at 35h alone
   property p_main_keeps_others;
      (main_s2_r && !(wr_cfg && (cfg_idx == 3'h0))) |=> (cfg_r[0] == $past(cfg_r[0]));
   endproperty
   a_main_keeps_others: assert property (p_main_keeps_others) else $error("main reset hit other pin"); // RULE_06

   // bus side: stored values, readback and unmapped offsets
   property p_write_one_sel;
      (wr_cfg && (cfg_idx == 3'h0)) |=> (cfg_r[0] == ($past(i_wr_data) & MASK_ONE_SEL));
   endproperty
   a_write_one_sel: assert property (p_write_one_sel) else $error("one-bit selector write wrong"); // RULE_14

   property p_write_two_sel;
      (wr_cfg && (cfg_idx == IDX_TWO_SEL)) |=> (cfg_r[IDX_TWO_SEL] == ($past(i_wr_data) & MASK_TWO_SEL));
   endproperty
   a_write_two_sel: assert property (p_write_two_sel) else $error("two-bit selector write wrong"); // RULE_14

   property p_cfg_readback;
      (i_rd && cfg_hit) |=> (o_rd_data == $past(cfg_at_addr));
   endproperty
   a_cfg_readback: assert property (p_cfg_readback) else $error("config readback wrong"); // RULE_14

   property p_unmapped_read;
      (i_rd && !cfg_hit && (i_addr != OFF_DATA_OUT) && (i_addr != OFF_PIN_LEVEL)
         && (i_addr != OFF_IRQ_STATUS) && (i_addr != OFF_IRQ_MASK)) |=> (o_rd_data == 8'h00);
   endproperty
   a_unmapped_read: assert property (p_unmapped_read) else $error("unmapped read nonzero"); // RULE_14

   // pad side over all pins at once; an input or a released drain never sources current
   property p_inputs_released;
      (($past(dir_in) & o_pin_oe) == '0);
   endproperty
   a_inputs_released: assert property (p_inputs_released) else $error("input pin driven"); // RULE_01

   property p_drain_never_high;
      (($past(odrain) & o_pin_out) == '0);
   endproperty
   a_drain_never_high: assert property (p_drain_never_high) else $error("open drain pin driven high"); // RULE_03

   // interrupt bookkeeping
   property p_irq_level;
      (o_irq == (irq_status_r & irq_mask_r));
   endproperty
   a_irq_level: assert property (p_irq_level) else $error("interrupt level wrong"); // RULE_13

   property p_set_wins;
      (edge_evt && wr_status && i_wr_data[0]) |=> irq_status_r;
   endproperty
   a_set_wins: assert property (p_set_wins) else $error("clear beat a new edge"); // RULE_13

   property p_status_clear;
      (!edge_evt && wr_status && i_wr_data[0]) |=> !irq_status_r;
   endproperty
   a_status_clear: assert property (p_status_clear) else $error("status not cleared"); // RULE_13

   property p_no_event_plain;
      (!edge_mode && !irq_status_r) |=> !irq_status_r;
   endproperty
   a_no_event_plain: assert property (p_no_event_plain) else $error("status set outside edge mode"); // RULE_13

   c_edge_irq: cover property (edge_mode && $changed(pin_s2_r[7]) ##1 o_irq);
   c_status_clear: cover property (irq_status_r && wr_status && i_wr_data[0] ##1 !irq_status_r);
   c_open_drain_alt: cover property (cfg_r[0] == 8'h84 ##1 o_pin_oe[0]);
   c_fan_cleared: cover property (main_s2_r && cfg_r[IDX_FAN] != FAN_MAIN_RESET);
   c_set_over_clear: cover property (edge_evt && wr_status && i_wr_data[0]);

endmodule // gpio_pin_config

//--- testbench/gpio_board_model.sv
`timescale 1ns/1ps
// board side of the eight pads: pull-ups plus an optional external driver
module gpio_board_model (
   input  wire logic [7:0] i_pin_out,
   input  wire logic [7:0] i_pin_oe,
   input  wire logic [7:0] i_ext_en,
   input  wire logic [7:0] i_ext_val,
   output logic      [7:0] o_level
);
   // device drive wins, then the external driver; a pad neither drives floats up to the pull-up, never holds a stale value
   always_comb begin
      for (int k = 0; k < 8; k++) begin
         o_level[k] = i_pin_oe[k] ? i_pin_out[k] : (i_ext_en[k] ? i_ext_val[k] : 1'b1);
      end
   end
endmodule // gpio_board_model

//--- testbench/gpio_pin_config_group3_4_tb.sv
`timescale 1ns/1ps
module gpio_pin_config_group3_4_tb;
   import gpio_cfg_pkg::*;
   logic       i_ref_clk = 1'b0;
   logic       i_rst     = 1'b1;
   logic       i_main_rst = 1'b0;
   logic [7:0] i_addr = 8'h00, i_wr_data = 8'h00, alt = 8'h00, ext_en = 8'h00, ext_val = 8'h00;
   logic       i_wr = 1'b0, i_rd = 1'b0;
   logic [7:0] o_rd_data, o_pin_out, o_pin_oe, o_pin_value, level;
   logic       o_irq;
   int         failures = 0;
   int         n_compared = 0;

   // 50 MHz reference clock
   always #10 i_ref_clk = ~i_ref_clk;

   gpio_pin_config gpio_pin_config_i (.i_ref_clk(i_ref_clk), .i_rst(i_rst), .i_main_rst(i_main_rst),
      .i_addr(i_addr), .i_wr_data(i_wr_data), .i_wr(i_wr), .i_rd(i_rd), .o_rd_data(o_rd_data),
      .i_pin_level(level), .o_pin_out(o_pin_out), .o_pin_oe(o_pin_oe), .o_pin_value(o_pin_value),
      .i_smbus_data_line(alt[0]), .i_fan_ctrl(alt[1]), .i_irq12(alt[2]), .i_irq14(alt[3]),
      .i_keyboard_reset_out_n(alt[4]), .i_gate_address20_out_n(alt[5]),
      .i_drive_density_select0(alt[6]), .i_drive_density_select1(alt[7]), .o_irq(o_irq));
   gpio_board_model gpio_board_model_i (.i_pin_out(o_pin_out), .i_pin_oe(o_pin_oe), .i_ext_en(ext_en),
      .i_ext_val(ext_val), .o_level(level));

   task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
      n_compared++;
      if (got !== exp) begin
         $display("ERROR %s expected %h seen %h", what, exp, got);
         failures++;
      end
   endtask
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge i_ref_clk);
      i_wr <= 1'b1; i_addr <= a; i_wr_data <= d;
      @(posedge i_ref_clk);
      i_wr <= 1'b0;
   endtask
   // read data stand only in the cycle after the strobe edge
   task automatic rd(input logic [7:0] a, input logic [7:0] exp);
      @(posedge i_ref_clk);
      i_rd <= 1'b1; i_addr <= a;
      @(posedge i_ref_clk);
      i_rd <= 1'b0;
      #1 chk($sformatf("reg %h", a), exp, o_rd_data);
   endtask
   task automatic all_cfg(input logic [7:0] d);
      for (int k = 0; k < 8; k++) wr(OFF_PORT3_PIN2 + 8'(k), d);
   endtask
   task automatic settle(input int n);
      repeat (n) @(posedge i_ref_clk);
      #1;
   endtask

   task automatic t_reset_map;
      for (int k = 0; k < 8; k++) rd(OFF_PORT3_PIN2 + 8'(k), 8'h01);
      chk("oe after reset", 8'h00, o_pin_oe);
      wr(8'h60, 8'hff);
      rd(8'h60, 8'h00);
      all_cfg(8'hff);
      for (int k = 0; k < 7; k++) rd(OFF_PORT3_PIN2 + 8'(k), 8'h87);
      rd(OFF_PORT4_PIN1, 8'h8f);
      $display("test reset_map done");
   endtask
   task automatic t_drive;
      wr(OFF_DATA_OUT, 8'hff);
      all_cfg(8'h00);
      settle(3);
      chk("oe output", 8'hff, o_pin_oe);
      chk("out output", 8'hff, o_pin_out);
      all_cfg(8'h02);
      settle(3);
      chk("out inverted", 8'h00, o_pin_out);
      all_cfg(8'h80);
      settle(3);
      chk("oe drain released", 8'h00, o_pin_oe);
      wr(OFF_DATA_OUT, 8'h00);
      settle(3);
      chk("oe drain low", 8'hff, o_pin_oe);
      chk("out drain low", 8'h00, o_pin_out);
      all_cfg(8'h03);
      ext_en <= 8'hff; ext_val <= 8'ha5;
      settle(5);
      chk("value inverted", 8'h5a, o_pin_value);
      rd(OFF_PIN_LEVEL, 8'h5a);
      $display("test drive done");
   endtask
   task automatic t_alternate;
      ext_en <= 8'h00;
      all_cfg(8'h04);
      alt <= 8'h5a;
      settle(3);
      chk("alt out a", 8'h5a, o_pin_out);
      @(posedge i_ref_clk);
      alt <= 8'ha5;
      settle(3);
      chk("alt out b", 8'ha5, o_pin_out);
      wr(OFF_PORT4_PIN1, 8'h08);
      settle(3);
      chk("edge sel oe", 8'h7f, o_pin_oe);
      $display("test alternate done");
   endtask
   task automatic t_fan_reset;
      wr(OFF_PORT3_PIN3, 8'h85);
      i_main_rst <= 1'b1;
      settle(4);
      @(posedge i_ref_clk);
      i_main_rst <= 1'b0;
      settle(3);
      rd(OFF_PORT3_PIN3, 8'h00);
      rd(OFF_PORT3_PIN2, 8'h04);
      $display("test fan_reset done");
   endtask
   task automatic t_edge_irq;
      ext_en <= 8'h80; ext_val <= 8'h00;
      wr(OFF_PORT4_PIN1, 8'h09);
      settle(5);
      wr(OFF_IRQ_STATUS, 8'h01);
      wr(OFF_IRQ_MASK, 8'h01);
      settle(2);
      chk("irq idle", 8'h00, {7'h00, o_irq});
      ext_val <= 8'h80;
      settle(5);
      chk("irq rise", 8'h01, {7'h00, o_irq});
      rd(OFF_IRQ_STATUS, 8'h01);
      wr(OFF_IRQ_STATUS, 8'h01);
      settle(2);
      chk("irq cleared", 8'h00, {7'h00, o_irq});
      ext_val <= 8'h00;
      settle(5);
      chk("irq fall", 8'h01, {7'h00, o_irq});
      wr(OFF_IRQ_MASK, 8'h00);
      settle(2);
      chk("irq masked", 8'h00, {7'h00, o_irq});
      wr(OFF_PORT4_PIN1, 8'h0d);
      wr(OFF_IRQ_STATUS, 8'h01);
      ext_val <= 8'h80;
      settle(5);
      rd(OFF_IRQ_STATUS, 8'h00);
      $display("test edge_irq done");
   endtask

   task automatic results;
      $display("compared %0d failures %0d", n_compared, failures);
      if (failures == 0 && n_compared > 0) begin
         $display("bench passed");
      end else begin
         $display("bench failed");
      end
      $finish;
   endtask

   // watchdog: the tests need well under 2000 cycles
   initial begin
      #100000;
      failures++;
      results();
   end
   initial begin
      repeat (10) @(posedge i_ref_clk);
      i_rst <= 1'b0;
      t_reset_map();
      t_drive();
      t_alternate();
      t_fan_reset();
      t_edge_irq();
      results();
   end
endmodule // gpio_pin_config_group3_4_tb
